// *** hw/tpw_consts.svh ***
// timer pwm constants: register offsets, field positions, reset values, fixed tops
// assumes inclusion from the timer module and the test bench only
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH
`define TPW_OFS_CTRL      8'h00
`define TPW_OFS_CAP_TOP   8'h04
`define TPW_OFS_CMP_A     8'h08
`define TPW_OFS_CMP_B     8'h0c
`define TPW_OFS_COUNT     8'h10
`define TPW_OFS_STATUS    8'h14
`define TPW_OFS_PINS      8'h18
`define TPW_CTRL_WGM_LSB  0
`define TPW_CTRL_PRE_LSB  4
`define TPW_CTRL_COMA_LSB 8
`define TPW_CTRL_COMB_LSB 10
`define TPW_CTRL_DIRA_BIT 12
`define TPW_CTRL_DIRB_BIT 13
`define TPW_ST_OVF_BIT    0
`define TPW_ST_CMPA_BIT   1
`define TPW_ST_CMPB_BIT   2
`define TPW_ST_CAP_BIT    3
`define TPW_RST_WORD      16'h0000
`define TPW_TOP8          16'h00ff
`define TPW_TOP9          16'h01ff
`define TPW_TOP10         16'h03ff
`define TPW_MAX           16'hffff
`define TPW_DIV8          10'h007
`define TPW_DIV64         10'h03f
`define TPW_DIV256        10'h0ff
`define TPW_DIV1024       10'h3ff
`endif

// *** hw/tpw_pkg.sv ***
// timer pwm types: mode codes and the block state
// assumes the constants header sits beside it
package tpw_pkg;
  typedef enum logic [3:0] {
    TPW_WGM_NORMAL = 4'h0, TPW_WGM_PC8 = 4'h1, TPW_WGM_PC9 = 4'h2, TPW_WGM_PC10 = 4'h3,
    TPW_WGM_CTC_A = 4'h4, TPW_WGM_FP8 = 4'h5, TPW_WGM_FP9 = 4'h6, TPW_WGM_FP10 = 4'h7,
    TPW_WGM_PF_CAP = 4'h8, TPW_WGM_PF_A = 4'h9, TPW_WGM_PC_CAP = 4'ha, TPW_WGM_PC_A = 4'hb,
    TPW_WGM_CTC_CAP = 4'hc, TPW_WGM_RSV = 4'hd, TPW_WGM_FP_CAP = 4'he, TPW_WGM_FP_A = 4'hf
  } tpw_wgm_type;

  typedef struct packed {
    logic [15:0] counter_value;
    logic        count_down;
    logic [9:0]  prescale_count;
    logic [3:0]  waveform_mode_select;
    logic [2:0]  prescale_select;
    logic [1:0]  channel_a_output_mode;
    logic [1:0]  channel_b_output_mode;
    logic [1:0]  pin_direction_bit;
    logic [15:0] capture_top_value;
    logic [15:0] cmp_a_buf;
    logic [15:0] cmp_b_buf;
    logic [15:0] channel_a_compare_value;
    logic [15:0] channel_b_compare_value;
    logic        overflow_flag;
    logic [1:0]  compare_match_flag;
    logic        capture_flag;
    logic [1:0]  compare_output;
    logic        ph_write;
    logic [7:0]  ph_addr;
    logic [31:0] hrdata;
  } tpw_state_type;
endpackage

// *** hw/tpw_timer.sv ***
// 16-bit timer waveform generator: fast pwm and phase correct pwm, ahb-lite register slave
// assumes a single ahb-lite master, word accesses only, one clock CLOCK
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "tpw_consts.svh"

module tpw_timer
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // general port function and pins
  input  wire logic [1:0]  PORT_OUT,
  output logic      [1:0]  PIN_OUT,
  output logic      [1:0]  PIN_OE
);
  logic          rst_meta_q;
  logic          rst_sync_q;
  tpw_state_type s_q;
  tpw_state_type s_d;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // decoded mode
  logic        fast_mode;
  logic        pc_mode;
  logic        top_is_cap;
  logic        top_is_a;
  logic        fixed_top;
  logic [15:0] top_value;
  logic [15:0] fixed_mask;
  logic        tick;
  logic [9:0]  div_limit;
  logic        at_top;
  logic        at_bottom;
  logic        pc_down;
  logic [1:0]  match;
  logic [1:0]  comp_mode [2];
  logic [15:0] comp_val [2];
  logic        addr_phase;
  logic [15:0] wmask;
  logic [15:0] wr_cmp;

  always_comb begin
    fast_mode  = 1'b0;
    pc_mode    = 1'b0;
    top_is_cap = 1'b0;
    top_is_a   = 1'b0;
    fixed_top  = 1'b0;
    top_value  = `TPW_MAX;
    fixed_mask = `TPW_MAX;
    unique case (tpw_wgm_type'(s_q.waveform_mode_select))
      TPW_WGM_FP8, TPW_WGM_PC8: begin
        top_value  = `TPW_TOP8;
        fixed_mask = `TPW_TOP8;
        fixed_top  = 1'b1;
      end
      TPW_WGM_FP9, TPW_WGM_PC9: begin
        top_value  = `TPW_TOP9;
        fixed_mask = `TPW_TOP9;
        fixed_top  = 1'b1;
      end
      TPW_WGM_FP10, TPW_WGM_PC10: begin
        top_value  = `TPW_TOP10;
        fixed_mask = `TPW_TOP10;
        fixed_top  = 1'b1;
      end
      TPW_WGM_FP_CAP, TPW_WGM_PC_CAP, TPW_WGM_PF_CAP, TPW_WGM_CTC_CAP: begin
        top_value  = s_q.capture_top_value; // unbuffered, read live
        top_is_cap = 1'b1;
      end
      TPW_WGM_FP_A, TPW_WGM_PC_A, TPW_WGM_PF_A, TPW_WGM_CTC_A: begin
        top_value = s_q.channel_a_compare_value;
        top_is_a  = 1'b1;
      end
      TPW_WGM_NORMAL, TPW_WGM_RSV: begin
        top_value = `TPW_MAX;
      end
    endcase
    unique case (tpw_wgm_type'(s_q.waveform_mode_select))
      TPW_WGM_FP8, TPW_WGM_FP9, TPW_WGM_FP10, TPW_WGM_FP_CAP, TPW_WGM_FP_A: fast_mode = 1'b1;
      TPW_WGM_PC8, TPW_WGM_PC9, TPW_WGM_PC10, TPW_WGM_PC_CAP, TPW_WGM_PC_A: pc_mode = 1'b1;
      default: begin
        fast_mode = 1'b0;
        pc_mode   = 1'b0;
      end
    endcase
    unique case (s_q.prescale_select)
      3'h1:    div_limit = 10'h000;
      3'h2:    div_limit = `TPW_DIV8;
      3'h3:    div_limit = `TPW_DIV64;
      3'h4:    div_limit = `TPW_DIV256;
      3'h5:    div_limit = `TPW_DIV1024;
      default: div_limit = 10'h000;
    endcase
    tick      = (s_q.prescale_select inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) &&
                ((s_q.prescale_count & div_limit) == div_limit);
    at_top    = (s_q.counter_value == top_value);
    at_bottom = (s_q.counter_value == 16'h0000);
    // turning points act as the slope they start, so compare at bottom or top gives a flat level
    pc_down   = at_top || (s_q.count_down && !at_bottom);
    comp_mode[0] = s_q.channel_a_output_mode;
    comp_mode[1] = s_q.channel_b_output_mode;
    comp_val[0]  = s_q.channel_a_compare_value;
    comp_val[1]  = s_q.channel_b_compare_value;
    for (int i = 0; i < 2; i++) begin
      match[i] = (s_q.counter_value == comp_val[i]);
    end
    addr_phase = HSEL && HREADY && HTRANS[1];
    wmask      = fixed_top ? fixed_mask : `TPW_MAX;
    wr_cmp     = HWDATA[15:0] & wmask;
  end

  always_comb begin
    s_d = s_q;
    // ahb-lite: zero wait states, always okay; address latched for the data phase
    s_d.ph_write = addr_phase && HWRITE;
    s_d.ph_addr  = HADDR[7:0];
    if (addr_phase && !HWRITE) begin
      unique case (HADDR[7:0])
        `TPW_OFS_CTRL:    s_d.hrdata = {18'h00000, s_q.pin_direction_bit, s_q.channel_b_output_mode,
                                        s_q.channel_a_output_mode, 1'b0, s_q.prescale_select,
                                        s_q.waveform_mode_select};
        `TPW_OFS_CAP_TOP: s_d.hrdata = {16'h0000, s_q.capture_top_value};
        `TPW_OFS_CMP_A:   s_d.hrdata = {16'h0000, s_q.cmp_a_buf};
        `TPW_OFS_CMP_B:   s_d.hrdata = {16'h0000, s_q.cmp_b_buf};
        `TPW_OFS_COUNT:   s_d.hrdata = {15'h0000, s_q.count_down, s_q.counter_value};
        `TPW_OFS_STATUS:  s_d.hrdata = {28'h0000000, s_q.capture_flag, s_q.compare_match_flag,
                                        s_q.overflow_flag};
        `TPW_OFS_PINS:    s_d.hrdata = {30'h00000000, s_q.compare_output};
        default:          s_d.hrdata = 32'h00000000;
      endcase
    end

    // write one to clear comes first, so a hardware set in the same cycle wins
    if (s_q.ph_write && s_q.ph_addr == `TPW_OFS_STATUS) begin
      if (HWDATA[`TPW_ST_OVF_BIT]) begin
        s_d.overflow_flag = 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (HWDATA[`TPW_ST_CMPA_BIT + i]) begin
          s_d.compare_match_flag[i] = 1'b0;
        end
      end
      if (HWDATA[`TPW_ST_CAP_BIT]) begin
        s_d.capture_flag = 1'b0;
      end
    end

    // prescaler free-runs: a new divisor never waits for a full wrap before its first tick
    s_d.prescale_count = 10'(s_q.prescale_count + 10'h001);
    if (tick) begin
      if (fast_mode) begin
        // clear only on an exact top match, else wrap past 0xffff
        s_d.count_down    = 1'b0;
        s_d.counter_value = at_top ? 16'h0000 : 16'(s_q.counter_value + 16'h0001);
      end else if (pc_mode) begin
        // one cycle at top, then down; turn at bottom
        if (at_top && !s_q.count_down) begin
          s_d.count_down    = 1'b1;
          s_d.counter_value = 16'(s_q.counter_value - 16'h0001);
        end else if (s_q.count_down && at_bottom) begin
          s_d.count_down    = 1'b0;
          s_d.counter_value = 16'h0001;
        end else if (s_q.count_down) begin
          s_d.counter_value = 16'(s_q.counter_value - 16'h0001);
        end else begin
          s_d.counter_value = 16'(s_q.counter_value + 16'h0001);
        end
      end else begin
        s_d.count_down    = 1'b0;
        s_d.counter_value = 16'(s_q.counter_value + 16'h0001);
      end

      // buffer loads at top in both modes
      if ((fast_mode || (pc_mode && !s_q.count_down)) && at_top) begin
        s_d.channel_a_compare_value = s_q.cmp_a_buf;
        s_d.channel_b_compare_value = s_q.cmp_b_buf;
      end

      // flags: these sets land after the software clear above, so a set wins
      if (fast_mode && at_top) begin
        s_d.overflow_flag = 1'b1;
      end
      if (pc_mode && at_bottom && s_q.count_down) begin
        s_d.overflow_flag = 1'b1;
      end
      if ((fast_mode || (pc_mode && !s_q.count_down)) && at_top && top_is_cap) begin
        s_d.capture_flag = 1'b1;
      end

      // compare outputs
      for (int i = 0; i < 2; i++) begin
        if (match[i]) begin
          s_d.compare_match_flag[i] = 1'b1; // top-a match sets flag a
        end
        if (fast_mode) begin
          if (i == 0 && comp_mode[i] == 2'h1 && top_is_a && match[i]) begin
            s_d.compare_output[i] = !s_q.compare_output[i];
          end else if (comp_mode[i][1]) begin
            // match wins at top so compare equal to top gives a constant level
            if (match[i]) begin
              s_d.compare_output[i] = !comp_mode[i][0];
            end else if (at_top) begin
              s_d.compare_output[i] = comp_mode[i][0];
            end
          end
        end else if (pc_mode) begin
          if (i == 0 && comp_mode[i] == 2'h1 && top_is_a && match[i]) begin
            s_d.compare_output[i] = !s_q.compare_output[i];
          end else if (comp_mode[i][1] && match[i]) begin
            // non-inverting clears rising and sets falling; top counts as falling
            s_d.compare_output[i] = pc_down ^ comp_mode[i][0];
          end
        end
        // mode zero leaves the output register untouched
      end
    end

    // ahb-lite write data phase
    if (s_q.ph_write) begin
      unique case (s_q.ph_addr)
        `TPW_OFS_CTRL: begin
          s_d.waveform_mode_select  = HWDATA[`TPW_CTRL_WGM_LSB +: 4];
          s_d.prescale_select       = HWDATA[`TPW_CTRL_PRE_LSB +: 3];
          s_d.channel_a_output_mode = HWDATA[`TPW_CTRL_COMA_LSB +: 2];
          s_d.channel_b_output_mode = HWDATA[`TPW_CTRL_COMB_LSB +: 2];
          s_d.pin_direction_bit     = {HWDATA[`TPW_CTRL_DIRB_BIT], HWDATA[`TPW_CTRL_DIRA_BIT]};
        end
        `TPW_OFS_CAP_TOP: s_d.capture_top_value = HWDATA[15:0];
        `TPW_OFS_CMP_A: begin
          s_d.cmp_a_buf = wr_cmp;
          if (!(fast_mode || pc_mode)) begin
            s_d.channel_a_compare_value = wr_cmp;
          end
        end
        `TPW_OFS_CMP_B: begin
          s_d.cmp_b_buf = wr_cmp;
          if (!(fast_mode || pc_mode)) begin
            s_d.channel_b_compare_value = wr_cmp;
          end
        end
        `TPW_OFS_COUNT: s_d.counter_value = HWDATA[15:0];
        // status clears are handled above; other offsets leave a back-to-back read intact
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0; // output registers and all control start at zero
    end else begin
      s_q <= s_d;
    end
  end

  assign HRDATA    = s_q.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // pin override: mode nonzero selects the compare output, direction gates the driver
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      PIN_OUT[i] = (comp_mode[i] != 2'h0) ? s_q.compare_output[i] : PORT_OUT[i];
      PIN_OE[i]  = s_q.pin_direction_bit[i];
    end
  end

  fast_ovf_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && at_top) |=> s_q.overflow_flag && s_q.counter_value == 16'h0000)
    else $error("fast pwm top did not clear counter and set overflow");
  fast_up_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && !at_top && !s_q.ph_write) |=> s_q.counter_value == $past(s_q.counter_value) + 16'h0001)
    else $error("fast pwm counter did not step up");
  pc_hold_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && at_top && !s_q.count_down && !s_q.ph_write) |=> s_q.count_down)
    else $error("phase correct did not turn at top");
  pc_ovf_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && at_bottom && s_q.count_down) |=> s_q.overflow_flag && !s_q.count_down)
    else $error("phase correct bottom missing overflow");
  buf_load_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && at_top && !s_q.ph_write) |=> s_q.channel_b_compare_value == $past(s_q.cmp_b_buf))
    else $error("compare buffer not loaded at top");
  cmp_flag_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && (fast_mode || pc_mode) && match[1]) |=> s_q.compare_match_flag[1])
    else $error("compare flag not set on match");
  mask_wr_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (s_q.ph_write && s_q.ph_addr == `TPW_OFS_CMP_A && fixed_top) |=> (s_q.cmp_a_buf & ~$past(fixed_mask)) == 16'h0000)
    else $error("compare bits above resolution kept");
  pin_oe_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    !s_q.pin_direction_bit[0] |-> !PIN_OE[0])
    else $error("pin driven without direction bit");
  mode_zero_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (s_q.channel_b_output_mode == 2'h0) |=> $stable(s_q.compare_output[1]) || $past(s_q.ph_write))
    else $error("output changed with mode zero");
  // output checks watch channel a, the channel that runs both polarities and the toggle
  fast_set_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && match[0] && s_q.channel_a_output_mode == 2'h2) |=> s_q.compare_output[0])
    else $error("non-inverting fast pwm not set on match");
  fast_inv_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && match[0] && s_q.channel_a_output_mode == 2'h3) |=> !s_q.compare_output[0])
    else $error("inverting fast pwm not cleared on match");
  fast_clr_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && at_top && !match[0] && s_q.channel_a_output_mode == 2'h2) |=> !s_q.compare_output[0])
    else $error("non-inverting fast pwm not cleared at top");
  cap_flag_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && fast_mode && at_top && top_is_cap) |=> s_q.capture_flag)
    else $error("capture-top flag not set at top");
  toggle_out_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && (fast_mode || pc_mode) && top_is_a && match[0] && s_q.channel_a_output_mode == 2'h1) |=>
    s_q.compare_output[0] != $past(s_q.compare_output[0]))
    else $error("channel a did not toggle on match");
  pc_up_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && !s_q.count_down && !at_top && !s_q.ph_write) |=>
    s_q.counter_value == $past(s_q.counter_value) + 16'h0001)
    else $error("phase correct counter did not step up");
  pc_down_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && s_q.count_down && !at_bottom && !s_q.ph_write) |=>
    s_q.counter_value == $past(s_q.counter_value) - 16'h0001)
    else $error("phase correct counter did not step down");
  pc_top_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && at_top && match[0] && s_q.channel_a_output_mode == 2'h2) |=> s_q.compare_output[0])
    else $error("phase correct compare at top not high");
  pc_bottom_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && at_bottom && match[0] && s_q.channel_a_output_mode == 2'h2) |=> !s_q.compare_output[0])
    else $error("phase correct compare at bottom not low");
  pc_buf_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (tick && pc_mode && at_top && !s_q.count_down && !s_q.ph_write) |=>
    s_q.channel_b_compare_value == $past(s_q.cmp_b_buf))
    else $error("phase correct buffer not loaded at top");
  count_hold_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (!tick && !s_q.ph_write) |=> $stable(s_q.counter_value))
    else $error("counter moved without a timer tick");
  flag_hold_a: assert property (@(posedge CLOCK) disable iff (!rst_sync_q)
    (s_q.overflow_flag && !(s_q.ph_write && s_q.ph_addr == `TPW_OFS_STATUS)) |=> s_q.overflow_flag)
    else $error("overflow flag dropped without a clear");
endmodule

// *** test/tpw_load.sv ***
// external load on the two compare pins: counts cycles in which channel a drives high
// assumes the pins are sampled on the rising edge of the block clock
`timescale 1ns/1ps
module tpw_load (
  // clock and control
  input  wire logic        clk,
  input  wire logic        clr,
  // pins
  input  wire logic [1:0]  pin,
  input  wire logic [1:0]  oe,
  // measurement
  output logic      [15:0] hi_cnt
);
  // a pin without its driver enabled reads as low, as through a pull-down
  always_ff @(posedge clk) begin
    if (clr) begin
      hi_cnt <= 16'h0000;
    end else if (oe[0] && pin[0]) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
endmodule

// *** test/tpw_timer_test.sv ***
// self-checking bench for the timer pwm block: ahb-lite driver, pin probes and a pin load
// assumes a zero-wait slave whose HREADYOUT is fed back as HREADY
`timescale 1ns/1ps
`include "tpw_consts.svh"
module timer16_fast_and_phase_pwm_test
  import tpw_pkg::*;
;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
  } tpw_note_type;
  logic         CLOCK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, clr, probe;
  logic         rd_dp = 1'b0;
  logic [1:0]   HTRANS, PORT_OUT, PIN_OUT, PIN_OE;
  logic [2:0]   HSIZE;
  logic [31:0]  HADDR, HWDATA, HRDATA, r;
  logic [15:0]  hi_cnt;
  logic [15:0]  tops [3];
  int           divs [3] = '{1, 8, 64};
  int           n_mismatch, total_checks;
  tpw_note_type notes [$];

  tpw_timer tpw_timer_i (.CLOCK(CLOCK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_OUT(PORT_OUT), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
  tpw_load tpw_load_i (.clk(CLOCK), .clr(clr), .pin(PIN_OUT), .oe(PIN_OE), .hi_cnt(hi_cnt));

  always #12.5 CLOCK = ~CLOCK;

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h000000, a};
    HWRITE <= wr;
    HSIZE <= 3'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    bus(1'b0, a, 32'h00000000);
  endtask
  task automatic note_probe(input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    probe <= 1'b1;
    @(posedge CLOCK);
    probe <= 1'b0;
  endtask

  function automatic logic [31:0] ctl(logic [3:0] m, logic [2:0] p, logic [1:0] ca, logic [1:0] cb,
                                      logic [1:0] dir);
    return {18'h00000, dir, cb, ca, 1'b0, p, m};
  endfunction

  // compares are written in mode 0, where they load at once, so a stale compare never sets the first top;
  // every case keeps top at least 3, no compare above it, and top fixed while running
  task automatic pwm(input logic [3:0] m, input logic [2:0] p, input logic [1:0] ca, input logic [15:0] top,
                     input logic [15:0] cmp, input int win, input int hi);
    wr(`TPW_OFS_CTRL, 32'h00000000);
    wr(`TPW_OFS_STATUS, 32'h0000000f);
    wr(`TPW_OFS_CAP_TOP, {16'h0000, top});
    wr(`TPW_OFS_CMP_A, {16'h0000, cmp});
    wr(`TPW_OFS_CMP_B, {16'h0000, cmp});
    wr(`TPW_OFS_COUNT, 32'h00000000);
    wr(`TPW_OFS_CTRL, ctl(m, p, ca, 2'h3, 2'h3));
    // settle for a whole window, then count high cycles over a window of whole periods
    repeat (win) @(posedge CLOCK);
    clr <= 1'b1;
    @(posedge CLOCK);
    clr <= 1'b0;
    repeat (win) @(posedge CLOCK);
    note_probe({hi[15:0], 16'h0000}, 32'hffff0000);
  endtask

  // results are taken in the data phase of each read and at each pin probe
  task automatic compare(input logic [31:0] got);
    tpw_note_type n;
    total_checks++;
    if (notes.size() == 0) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: result without expectation", $time);
    end else begin
      n = notes.pop_front();
      if ((got & n.mask) !== (n.val & n.mask)) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: got %h expected %h mask %h", $time, got, n.val, n.mask);
      end
    end
  endtask
  always @(posedge CLOCK) begin
    if (rd_dp && HREADYOUT === 1'b1) begin
      compare(HRDATA);
    end
    if (probe === 1'b1) begin
      compare({hi_cnt, 12'h000, PIN_OE, PIN_OUT});
    end
    if (HREADYOUT === 1'b1) begin
      rd_dp = HSEL && HTRANS[1] && !HWRITE;
    end
  end

  initial begin
    #(25 * 40000);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    CLOCK = 1'b0;
    RST_N = 1'b0;
    HSEL = 1'b0;
    HADDR = 32'h00000000;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h00000000;
    PORT_OUT = 2'b00;
    clr = 1'b0;
    probe = 1'b0;
    tops = '{`TPW_TOP8, `TPW_TOP9, `TPW_TOP10};
    r = $urandom(32'h6299);
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLOCK);
    rd(`TPW_OFS_CTRL, 32'h00000000, 32'hffffffff);
    rd(`TPW_OFS_PINS, 32'h00000000, 32'hffffffff);
    rd(`TPW_OFS_STATUS, 32'h00000000, 32'hffffffff);
    rd(8'h1c, 32'h00000000, 32'hffffffff);
    note_probe(32'h00000000, 32'h0000000c);
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      PORT_OUT <= r[1:0];
      wr(`TPW_OFS_CTRL, ctl(TPW_WGM_FP_CAP, 3'h0, 2'h2, 2'h0, i[1:0]));
      note_probe({28'h0000000, i[1:0], r[1], 1'b0}, 32'h0000000f);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`TPW_OFS_CTRL, ctl(TPW_WGM_FP8 + i[3:0], 3'h0, 2'h2, 2'h0, 2'h3));
      wr(`TPW_OFS_CMP_A, 32'h0000ffff);
      rd(`TPW_OFS_CMP_A, {16'h0000, tops[i]}, 32'hffffffff);
    end
    for (int i = 0; i < 3; i++) begin
      pwm(TPW_WGM_FP8 + i[3:0], 3'h1, 2'h2, 16'h0009, tops[i] >> 1, 2 * (tops[i] + 1),
          2 * (tops[i] - (tops[i] >> 1)));
      pwm(TPW_WGM_FP_CAP, 3'h1 + i[2:0], 2'h2, 16'h0009, 16'h0003, 20 * divs[i], 12 * divs[i]);
    end
    pwm(TPW_WGM_FP_CAP, 3'h4, 2'h2, 16'h0003, 16'h0001, 1024, 512);
    pwm(TPW_WGM_FP_CAP, 3'h5, 2'h2, 16'h0003, 16'h0001, 4096, 2048);
    pwm(TPW_WGM_FP_CAP, 3'h1, 2'h3, 16'h0009, 16'h0003, 20, 8);
    pwm(TPW_WGM_FP_CAP, 3'h1, 2'h3, 16'h0009, 16'h0000, 20, 2);
    pwm(TPW_WGM_FP_CAP, 3'h1, 2'h3, 16'h0009, 16'h0009, 20, 0);
    pwm(TPW_WGM_FP_CAP, 3'h1, 2'h2, 16'h0009, 16'h0009, 20, 20);
    wr(`TPW_OFS_CTRL, 32'h00000000);
    rd(`TPW_OFS_STATUS, 32'h0000000f, 32'h0000000f);
    pwm(TPW_WGM_FP_A, 3'h1, 2'h1, 16'h0005, 16'h0005, 24, 12);
    pwm(TPW_WGM_PC_CAP, 3'h1, 2'h2, 16'h0008, 16'h0003, 32, 12);
    pwm(TPW_WGM_PC_CAP, 3'h1, 2'h3, 16'h0008, 16'h0003, 32, 20);
    pwm(TPW_WGM_PC_CAP, 3'h1, 2'h2, 16'h0008, 16'h0000, 32, 0);
    pwm(TPW_WGM_PC_CAP, 3'h1, 2'h2, 16'h0008, 16'h0008, 32, 32);
    pwm(TPW_WGM_PC8, 3'h1, 2'h2, 16'h0000, 16'h0040, 1020, 256);
    pwm(TPW_WGM_PC_A, 3'h1, 2'h1, 16'h0006, 16'h0006, 48, 24);
    wr(`TPW_OFS_CTRL, 32'h00000000);
    rd(`TPW_OFS_STATUS, 32'h00000007, 32'h00000007);
    wr(`TPW_OFS_STATUS, 32'h00000001);
    rd(`TPW_OFS_STATUS, 32'h00000006, 32'h00000007);
    // capture top set below the count: the match is missed until the counter wraps
    wr(`TPW_OFS_CTRL, ctl(TPW_WGM_FP_CAP, 3'h0, 2'h2, 2'h0, 2'h3));
    wr(`TPW_OFS_CAP_TOP, 32'h00000009);
    wr(`TPW_OFS_COUNT, 32'h0000ff00);
    wr(`TPW_OFS_STATUS, 32'h0000000f);
    wr(`TPW_OFS_CTRL, ctl(TPW_WGM_FP_CAP, 3'h1, 2'h2, 2'h0, 2'h3));
    repeat (20) @(posedge CLOCK);
    wr(`TPW_OFS_CTRL, ctl(TPW_WGM_FP_CAP, 3'h0, 2'h2, 2'h0, 2'h3));
    rd(`TPW_OFS_STATUS, 32'h00000000, 32'h00000008);
    rd(`TPW_OFS_COUNT, 32'h00008000, 32'h00018000);
    repeat (2) @(posedge CLOCK);
    if (notes.size() != 0) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: expectations left unanswered", $time);
    end
    final_report();
  end
endmodule
